/* File: design/mcs_host.sv */
// Host controller driving a flash memory card over its serial peripheral link
// Contract
// - Checksum bits may hold anything when checking is off; receiver ignores them.
// - Card starts with checking off; the mode-switching reset needs a valid checksum.
// - In serial mode command checksums are checked only while enabled by command.
// - Interface-condition command is always checked; mismatch gives checksum error response.
// - Every data block carries its own 16-bit CCITT checksum.
// - Partial reads allow 1 to 512 bytes within one sector, else 512.
// - High capacity hosts use 512-byte aligned blocks only.
// - Stop command ends a multiple block read.
// - Write command answered by response; host sends start token before each block.
// - Data response shows checksum and write errors only; host reads status afterwards.
// - Multiple write ends with stop token; after write error query good-block count.
// - Every token starts on an 8-clock boundary from select.
// - Command frames are 6 bytes, most significant bit first.
`include "mcs_map.svh"
module mcs_host #(
  parameter logic [15:0] DATA_WAIT_BYTES = 16'h1000,
  parameter logic [15:0] BUSY_WAIT_BYTES = 16'hFFFF
) (
  // System
  input wire logic clk,
  input wire logic ce,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire mcs_pkg::mcs_word_t wdata,
  input wire logic wr,
  input wire logic rd,
  output mcs_pkg::mcs_word_t rd_data_q,
  // Card link
  output logic sclk_q,
  output logic cs_n_q,
  output logic mosi_q,
  input wire logic miso
);
  import mcs_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic s1_q, s1_d, s2_q, s2_d;
  logic run_q, run_d, sclk_d, mosi_d, done_q, done_d;
  logic [2:0] half_q, half_d, bit_q, bit_d;
  mcs_byte_t tx_q, tx_d, rx_q, rx_d, tx_byte;
  mcs_state_t st_q, st_d, after_cmd, tail_st;
  logic [9:0] idx_q, idx_d, len_q, len_d;
  logic [15:0] cnt_q, cnt_d, crc;
  logic [1:0] gap_q, gap_d;
  logic [47:0] frame_q, frame_d;
  logic [16:0] ctl_q, ctl_d;
  mcs_byte_t resp_q, resp_d, tok_q, tok_d, rxc_q, rxc_d, buf_rdata;
  logic [5:0] flags_q, flags_d;
  logic cs_n_d, kick, start, crc_clr, crc_en, buf_we;
  mcs_word_t arg_q, arg_d, cfg_q, cfg_d, rd_data_d;
  logic [8:0] bufp_q, bufp_d, buf_raddr, buf_waddr;
  mcs_byte_t buf_wdata;
  logic [3:0] rise_q, rise_d;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [6:0] mcs_crc7(input logic [39:0] m);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = c[6] ^ m[i];
      c = {c[5:0], 1'b0} ^ (fb ? `MCS_CRC7_POLY : 7'h00);
    end
    return c;
  endfunction : mcs_crc7

  function automatic logic [9:0] mcs_eff_len(input mcs_word_t cfg, input logic reg16);
    if (reg16) begin
      return `MCS_REG_LEN;
    end else if (cfg[`MCS_F_HC]) begin
      return `MCS_BLK_MAX;
    end
    return cfg[`MCS_F_LEN];
  endfunction : mcs_eff_len

  // Partial byte-addressed transfers must not leave their sector; others must be 512 bytes
  function automatic logic mcs_len_bad(input mcs_word_t cfg, input mcs_word_t arg);
    logic [10:0] span;
    span = {2'h0, arg[8:0]} + {1'h0, cfg[`MCS_F_LEN]};
    if (cfg[`MCS_F_HC]) begin
      return 1'b0;
    end else if (!cfg[`MCS_F_PART]) begin
      return cfg[`MCS_F_LEN] != `MCS_BLK_MAX;
    end
    return cfg[`MCS_F_LEN] == 10'h000 || span > {1'h0, `MCS_BLK_MAX};
  endfunction : mcs_len_bad

  // ****************************************
  // Byte shifter
  // ****************************************
  assign kick = !run_q && !done_q && gap_q == 2'h0 && st_q != st_idle;

  always_comb begin
    case (st_q)
      st_cmd: tx_byte = frame_q[47:40];
      st_txtok: tx_byte = ctl_q[`MCS_C_STOP] ? `MCS_TOK_STOP :
        (ctl_q[`MCS_C_MULTI] ? `MCS_TOK_MULTI : `MCS_TOK_START);
      st_txdata: tx_byte = buf_rdata;
      st_txcrc: tx_byte = idx_q[0] ? crc[7:0] : crc[15:8];
      default: tx_byte = `MCS_IDLE_BYTE;
    endcase
  end

  always_comb begin
    s1_d = miso;
    s2_d = s1_q;
    run_d = run_q;
    sclk_d = sclk_q;
    mosi_d = mosi_q;
    half_d = half_q;
    bit_d = bit_q;
    tx_d = tx_q;
    rx_d = rx_q;
    done_d = 1'b0;
    if (kick) begin
      run_d = 1'b1;
      mosi_d = tx_byte[7];
      tx_d = {tx_byte[6:0], 1'b1};
      half_d = 3'(`MCS_HALF_CYC - 1);
      bit_d = 3'h0;
    end else if (run_q) begin
      if (half_q != 3'h0) begin
        half_d = half_q - 3'h1;
      end else begin
        half_d = 3'(`MCS_HALF_CYC - 1);
        if (!sclk_q) begin
          sclk_d = 1'b1;
        end else begin
          // Sampled late in the high phase so the synchroniser delay stays inside it
          sclk_d = 1'b0;
          rx_d = {rx_q[6:0], s2_q};
          mosi_d = tx_q[7];
          tx_d = {tx_q[6:0], 1'b1};
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            run_d = 1'b0;
            done_d = 1'b1;
            mosi_d = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      run_q <= 1'b0;
      sclk_q <= 1'b0;
      mosi_q <= 1'b1;
      half_q <= 3'h0;
      bit_q <= 3'h0;
      tx_q <= 8'hFF;
      rx_q <= 8'hFF;
      done_q <= 1'b0;
    end else if (ce) begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      run_q <= run_d;
      sclk_q <= sclk_d;
      mosi_q <= mosi_d;
      half_q <= half_d;
      bit_q <= bit_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      done_q <= done_d;
    end
  end

  // ****************************************
  // Transaction sequencer
  // ****************************************
  assign start = wr && addr == `MCS_A_CTRL && wdata[`MCS_C_OPS] != 7'h00;
  assign tail_st = ctl_q[`MCS_C_KEEP] ? st_idle : st_tail;
  assign after_cmd = ctl_q[`MCS_C_BUSY] ? st_busy : ctl_q[`MCS_C_RX] ? st_tokwait :
    ctl_q[`MCS_C_TX] ? st_txtok : tail_st;

  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    gap_d = (gap_q != 2'h0) ? gap_q - 2'h1 : gap_q;
    frame_d = frame_q;
    ctl_d = ctl_q;
    len_d = len_q;
    resp_d = resp_q;
    tok_d = tok_q;
    rxc_d = rxc_q;
    cs_n_d = cs_n_q;
    flags_d = flags_q;
    if (st_q == st_idle) begin
      if (start) begin
        flags_d = 6'h00;
        if (wdata[`MCS_C_CMD] && (wdata[`MCS_C_RX] || wdata[`MCS_C_TX]) &&
            !wdata[`MCS_C_REG16] && mcs_len_bad(cfg_q, arg_q)) begin
          flags_d[`MCS_G_PARAM] = 1'b1;
        end else begin
          ctl_d = wdata[`MCS_C_W];
          tok_d = 8'h00;
          idx_d = 10'h000;
          cnt_d = 16'h0000;
          gap_d = `MCS_GAP;
          // Checksum always correct: harmless when checking is off, needed otherwise
          frame_d = {`MCS_FRAME_HEAD, wdata[`MCS_C_IDX], arg_q,
            mcs_crc7({`MCS_FRAME_HEAD, wdata[`MCS_C_IDX], arg_q}), `MCS_FRAME_TAIL};
          len_d = mcs_eff_len(cfg_q, wdata[`MCS_C_REG16]);
          cs_n_d = wdata[`MCS_C_WAKE];
          if (wdata[`MCS_C_WAKE]) begin
            st_d = st_wake;
          end else if (wdata[`MCS_C_CMD]) begin
            st_d = st_cmd;
          end else if (wdata[`MCS_C_TX] || wdata[`MCS_C_STOP]) begin
            st_d = st_txtok;
          end else if (wdata[`MCS_C_RX]) begin
            st_d = st_tokwait;
          end else begin
            st_d = st_busy;
          end
        end
      end
    end else if (done_q) begin
      gap_d = `MCS_GAP;
      case (st_q)
        st_wake: begin
          cnt_d = cnt_q + 16'h0001;
          if (cnt_q == `MCS_WAKE_LAST) begin
            st_d = st_idle;
          end
        end
        st_cmd: begin
          frame_d = {frame_q[39:0], 8'hFF};
          idx_d = idx_q + 10'h001;
          if (idx_q == `MCS_FRAME_LAST) begin
            st_d = st_resp;
            cnt_d = 16'h0000;
          end
        end
        st_resp: begin
          cnt_d = cnt_q + 16'h0001;
          // The byte right after a stop command is stuffing
          if (!rx_q[7] && !(cnt_q == 16'h0000 && ctl_q[`MCS_C_IDX] == `MCS_CMD_STOP)) begin
            resp_d = rx_q;
            cnt_d = 16'h0000;
            st_d = ((rx_q & `MCS_RESP_REJECT) != 8'h00) ? tail_st : after_cmd;
          end else if (cnt_q == `MCS_RESP_LAST) begin
            flags_d[`MCS_G_TMO] = 1'b1;
            st_d = tail_st;
          end
        end
        st_tokwait: begin
          cnt_d = cnt_q + 16'h0001;
          if (rx_q == `MCS_TOK_START) begin
            st_d = st_rxdata;
            idx_d = 10'h000;
          end else if (rx_q[7:4] == 4'h0 && rx_q != 8'h00) begin
            tok_d = rx_q;
            flags_d[`MCS_G_TOKERR] = 1'b1;
            st_d = tail_st;
          end else if (cnt_q == (ctl_q[`MCS_C_REG16] ? `MCS_RESP_LAST : DATA_WAIT_BYTES - 16'h1)) begin
            flags_d[`MCS_G_TMO] = 1'b1;
            st_d = tail_st;
          end
        end
        st_rxdata: begin
          idx_d = idx_q + 10'h001;
          if (idx_q == len_q - 10'h001) begin
            st_d = st_rxcrc;
            idx_d = 10'h000;
          end
        end
        st_rxcrc: begin
          rxc_d = rx_q;
          idx_d = idx_q + 10'h001;
          if (idx_q[0]) begin
            if (cfg_q[`MCS_F_CRCCHK] && {rxc_q, rx_q} != crc) begin
              flags_d[`MCS_G_CRCERR] = 1'b1;
            end
            st_d = tail_st;
          end
        end
        st_txtok: begin
          idx_d = 10'h000;
          cnt_d = 16'h0000;
          st_d = ctl_q[`MCS_C_STOP] ? st_busy : st_txdata;
        end
        st_txdata: begin
          idx_d = idx_q + 10'h001;
          if (idx_q == len_q - 10'h001) begin
            st_d = st_txcrc;
            idx_d = 10'h000;
          end
        end
        st_txcrc: begin
          idx_d = idx_q + 10'h001;
          if (idx_q[0]) begin
            st_d = st_dresp;
          end
        end
        st_dresp: begin
          tok_d = rx_q;
          flags_d[`MCS_G_WRCRC] = rx_q[3:1] == `MCS_DRESP_CRC;
          flags_d[`MCS_G_WRERR] = rx_q[3:1] == `MCS_DRESP_WR;
          cnt_d = 16'h0000;
          st_d = st_busy;
        end
        st_busy: begin
          // Select stays low so the busy level stays visible
          cnt_d = cnt_q + 16'h0001;
          if (rx_q == `MCS_IDLE_BYTE && cnt_q != 16'h0000) begin
            st_d = tail_st;
          end else if (cnt_q == BUSY_WAIT_BYTES - 16'h1) begin
            flags_d[`MCS_G_TMO] = 1'b1;
            st_d = tail_st;
          end
        end
        st_tail: begin
          cs_n_d = 1'b1;
          st_d = st_idle;
        end
        default: st_d = st_idle;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= st_idle;
      idx_q <= 10'h000;
      cnt_q <= 16'h0000;
      gap_q <= 2'h0;
      frame_q <= 48'h0;
      ctl_q <= 17'h0;
      len_q <= `MCS_BLK_MAX;
      resp_q <= 8'hFF;
      tok_q <= 8'h00;
      rxc_q <= 8'h00;
      cs_n_q <= 1'b1;
      flags_q <= 6'h00;
    end else if (ce) begin
      st_q <= st_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      gap_q <= gap_d;
      frame_q <= frame_d;
      ctl_q <= ctl_d;
      len_q <= len_d;
      resp_q <= resp_d;
      tok_q <= tok_d;
      rxc_q <= rxc_d;
      cs_n_q <= cs_n_d;
      flags_q <= flags_d;
    end
  end

  // ****************************************
  // Buffer and checksum
  // ****************************************
  assign crc_clr = done_q && (st_q == st_tokwait || st_q == st_txtok);
  assign crc_en = (done_q && st_q == st_rxdata) || (kick && st_q == st_txdata);
  assign buf_we = (st_q != st_idle) ? (done_q && st_q == st_rxdata) :
    (wr && addr == `MCS_A_BUFD);
  assign buf_waddr = (st_q != st_idle) ? idx_q[8:0] : bufp_q;
  assign buf_wdata = (st_q != st_idle) ? rx_q : wdata[7:0];
  // Lookahead keeps back-to-back buffer reads one byte apart
  assign buf_raddr = (st_q != st_idle) ? idx_q[8:0] : bufp_d;

  mcs_crc16 u_crc (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .clr(crc_clr),
    .en(crc_en),
    .din((st_q == st_rxdata) ? rx_q : buf_rdata),
    .crc_q(crc)
  );

  mcs_buf u_buf (
    .clk(clk),
    .ce(ce),
    .we(buf_we),
    .waddr(buf_waddr),
    .wdata(buf_wdata),
    .raddr(buf_raddr),
    .rdata_q(buf_rdata)
  );

  // ****************************************
  // Register file
  // ****************************************
  always_comb begin
    arg_d = arg_q;
    cfg_d = cfg_q;
    bufp_d = bufp_q;
    rd_data_d = 32'h0000_0000;
    if (wr && st_q == st_idle) begin
      if (addr == `MCS_A_ARG) begin
        arg_d = wdata;
      end
      if (addr == `MCS_A_CFG) begin
        cfg_d = wdata;
      end
      if (addr == `MCS_A_BUFP) begin
        bufp_d = wdata[8:0];
      end
    end
    if ((wr || rd) && addr == `MCS_A_BUFD && st_q == st_idle) begin
      bufp_d = bufp_q + 9'h001;
    end
    if (rd) begin
      case (addr)
        `MCS_A_CTRL: rd_data_d = {15'h0000, ctl_q};
        `MCS_A_ARG: rd_data_d = arg_q;
        `MCS_A_CFG: rd_data_d = cfg_q;
        `MCS_A_STAT: rd_data_d = {8'h00, tok_q, 1'b0, flags_q, st_q != st_idle, resp_q};
        `MCS_A_BUFP: rd_data_d = {23'h000000, bufp_q};
        `MCS_A_BUFD: rd_data_d = {24'h000000, buf_rdata};
        default: rd_data_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arg_q <= 32'h0000_0000;
      cfg_q <= `MCS_CFG_RST;
      bufp_q <= 9'h000;
      rd_data_q <= 32'h0000_0000;
    end else if (ce) begin
      arg_q <= arg_d;
      cfg_q <= cfg_d;
      bufp_q <= bufp_d;
      rd_data_q <= rd_data_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  always_comb begin
    rise_d = kick ? 4'h0 : rise_q;
    if (run_q && sclk_d && !sclk_q) begin
      rise_d = rise_q + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rise_q <= 4'h0;
    end else if (ce) begin
      rise_q <= rise_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  cs_align_a: assert property (sclk_q && st_q != st_wake |-> !cs_n_q)
    else $error("clock pulse outside select");
  mode_zero_a: assert property ($rose(sclk_q) && ce |-> $stable(mosi_q) [*4])
    else $error("data changed while clock high");
  byte_bits_a: assert property (done_q |-> rise_q == 4'h8)
    else $error("byte without eight clocks");
  cmd_six_a: assert property (st_q == st_cmd && st_d == st_resp |-> idx_q == `MCS_FRAME_LAST)
    else $error("command frame not six bytes");
  start_tok_a: assert property (kick && st_q == st_txtok |->
    tx_byte inside {`MCS_TOK_START, `MCS_TOK_MULTI, `MCS_TOK_STOP})
    else $error("block not led by a token");
  busy_wait_a: assert property (ce && done_q && st_q == st_busy && rx_q != `MCS_IDLE_BYTE &&
    cnt_q != BUSY_WAIT_BYTES - 16'h1 |=> st_q == st_busy)
    else $error("busy left while card low");
  tok_err_a: assert property (ce && done_q && st_q == st_tokwait && rx_q[7:4] == 4'h0 &&
    rx_q != 8'h00 |=> flags_q[`MCS_G_TOKERR] && st_q != st_rxdata)
    else $error("error token not reported");
  crc_err_a: assert property (ce && done_q && st_q == st_rxcrc && idx_q[0] &&
    cfg_q[`MCS_F_CRCCHK] && {rxc_q, rx_q} != crc |=> flags_q[`MCS_G_CRCERR])
    else $error("block checksum mismatch missed");

  read_block_c: cover property (done_q && st_q == st_rxcrc && idx_q[0]);
  write_block_c: cover property (done_q && st_q == st_dresp);
  busy_end_c: cover property (done_q && st_q == st_busy && rx_q == `MCS_IDLE_BYTE);
endmodule : mcs_host

/* File: include/mcs_map.svh */
// Register map, field positions, tokens and timing constants of the card link host
`ifndef MCS_MAP_SVH
`define MCS_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define MCS_A_CTRL 8'h00
`define MCS_A_ARG 8'h04
`define MCS_A_CFG 8'h08
`define MCS_A_STAT 8'h0C
`define MCS_A_BUFP 8'h10
`define MCS_A_BUFD 8'h14
// ****************************************
// Control fields
// ****************************************
`define MCS_C_IDX 5:0
`define MCS_C_OPS 14:8
`define MCS_C_CMD 8
`define MCS_C_RX 9
`define MCS_C_TX 10
`define MCS_C_STOP 11
`define MCS_C_KEEP 12
`define MCS_C_WAKE 13
`define MCS_C_BUSY 14
`define MCS_C_REG16 15
`define MCS_C_MULTI 16
`define MCS_C_W 16:0
// ****************************************
// Configuration fields
// ****************************************
`define MCS_F_LEN 9:0
`define MCS_F_HC 10
`define MCS_F_PART 11
`define MCS_F_CRCCHK 12
`define MCS_CFG_RST 32'h0000_1200
// ****************************************
// Status flag positions
// ****************************************
`define MCS_G_TOKERR 0
`define MCS_G_CRCERR 1
`define MCS_G_TMO 2
`define MCS_G_PARAM 3
`define MCS_G_WRCRC 4
`define MCS_G_WRERR 5
// ****************************************
// Tokens and frame layout
// ****************************************
`define MCS_TOK_START 8'hFE
`define MCS_TOK_MULTI 8'hFC
`define MCS_TOK_STOP 8'hFD
`define MCS_IDLE_BYTE 8'hFF
`define MCS_DRESP_CRC 3'h5
`define MCS_DRESP_WR 3'h6
`define MCS_CMD_STOP 6'h0C
`define MCS_FRAME_HEAD 2'h1
`define MCS_FRAME_TAIL 1'h1
`define MCS_FRAME_LAST 10'h005
`define MCS_RESP_REJECT 8'h7E
`define MCS_CRC7_POLY 7'h09
`define MCS_CRC16_POLY 16'h1021
`define MCS_BLK_MAX 10'h200
`define MCS_REG_LEN 10'h010
// ****************************************
// Counts and timing
// ****************************************
`define MCS_RESP_LAST 16'h0007
`define MCS_WAKE_LAST 16'h0009
`define MCS_GAP 2'h2
`define MCS_CLK_NS 50
`define MCS_HALF_NS 200
`define MCS_HALF_CYC ((`MCS_HALF_NS + `MCS_CLK_NS - 1) / `MCS_CLK_NS)
`endif

/* File: include/mcs_pkg.sv */
// Types shared by the card link host modules
package mcs_pkg;
  typedef logic [7:0] mcs_byte_t;
  typedef logic [31:0] mcs_word_t;
  typedef enum logic [3:0] {
    st_idle, st_wake, st_cmd, st_resp, st_tokwait, st_rxdata, st_rxcrc,
    st_txtok, st_txdata, st_txcrc, st_dresp, st_busy, st_tail
  } mcs_state_t;
endpackage : mcs_pkg

/* File: design/mcs_buf.sv */
// Block buffer of 512 bytes with a registered read port
module mcs_buf (
  // System
  input wire logic clk,
  input wire logic ce,
  // Write port
  input wire logic we,
  input wire logic [8:0] waddr,
  input wire mcs_pkg::mcs_byte_t wdata,
  // Read port
  input wire logic [8:0] raddr,
  output mcs_pkg::mcs_byte_t rdata_q
);
  import mcs_pkg::*;
  mcs_byte_t mem [0:511];

  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];
    end
  end
endmodule : mcs_buf

/* File: design/mcs_crc16.sv */
// Bytewise CCITT checksum for data blocks
module mcs_crc16 (
  // System
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic clr,
  input wire logic en,
  input wire mcs_pkg::mcs_byte_t din,
  // Result
  output logic [15:0] crc_q
);
  import mcs_pkg::*;
  logic [15:0] crc_d;

  function automatic logic [15:0] mcs_crc16_byte(input logic [15:0] c, input mcs_byte_t d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0} ^ (fb ? `MCS_CRC16_POLY : 16'h0000);
    end
    return r;
  endfunction : mcs_crc16_byte

  always_comb begin
    crc_d = crc_q;
    if (clr) begin
      crc_d = 16'h0000;
    end else if (en) begin
      crc_d = mcs_crc16_byte(crc_q, din);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      crc_q <= 16'h0000;
    end else if (ce) begin
      crc_q <= crc_d;
    end
  end
endmodule : mcs_crc16

/* File: tb/mcs_card.sv */
// Behavioural card that answers the host on the serial link
module mcs_card #(
  parameter int LEN = 4
) (
  // Link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso
);
  logic [7:0] sh, tx, idx, rsp, q[$];
  logic [15:0] c, r;
  logic [31:0] a;
  int n, fc, wc;
  bit ww, idle = 1'b1;
  function automatic logic [15:0] crc(logic [15:0] v, logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      v = {v[14:0], 1'b0} ^ ((v[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    end
    return v;
  endfunction : crc
  function automatic logic [6:0] crc7(logic [39:0] m);
    logic [6:0] v;
    v = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      v = {v[5:0], 1'b0} ^ ((v[6] ^ m[i]) ? 7'h09 : 7'h00);
    end
    return v;
  endfunction : crc7
  task automatic answer(logic [7:0] k);
    if (idx == 8'h00) begin
      q.delete();
      idle = 1'b1;
    end
    if (idx == 8'h29) idle = 1'b0;
    q.push_back(8'hFF);
    rsp = (idx inside {8'h00, 8'h08, 8'h3A, 8'h3B}) ? 8'h01 : 8'h05;
    if ((idx == 8'h00 || idx == 8'h08) && k != {crc7({2'b01, idx[5:0], a}), 1'b1}) begin
      q.push_back(8'h09);
    end else begin
      q.push_back(idle ? rsp : 8'h00);
    end
    ww = (idx == 8'h18 || idx == 8'h19);
    if (idx == 8'h26) begin
      q.push_back(8'h00);
      q.push_back(8'h00);
    end
    if (idx == 8'h11 && a == 32'h0000_0BAD) begin
      q.push_back(8'h08);
    end else if (idx inside {8'h09, 8'h11, 8'h12}) begin
      c = 16'h0000;
      q.push_back(8'hFE);
      for (int i = 0; i < (idx == 8'h09 ? 16 : LEN); i++) begin
        q.push_back(8'hA0 + i[7:0]);
        c = crc(c, 8'hA0 + i[7:0]);
      end
      q.push_back(c[15:8]);
      // One argument value spoils the checksum on purpose
      q.push_back(c[7:0] ^ {7'h00, a == 32'h0000_0C00});
    end
  endtask : answer
  task automatic got(logic [7:0] b);
    if (wc > 0) begin
      wc--;
      if (wc >= 2) c = crc(c, b);
      else r = {r[7:0], b};
      if (wc == 0) begin
        q.push_back(r == c && a != 32'h0000_0BAD ? 8'h05 : 8'h0B);
        q.push_back(8'h00);
        q.push_back(8'h00);
      end
    end else if (fc > 0) begin
      // Checksum byte is examined only where it is always required
      if (fc < 5) a = {a[23:0], b};
      else answer(b);
      fc = (fc == 5) ? 0 : fc + 1;
    end else if (b[7:6] == 2'b01) begin
      fc = 1;
      idx = {2'b00, b[5:0]};
      ww = 0;
    end else if (ww && (b == 8'hFE || b == 8'hFC)) begin
      wc = LEN + 2;
      c = 16'h0000;
    end else if (b == 8'hFD) begin
      q.push_back(8'h00);
    end
  endtask : got
  always @(negedge cs_n) begin
    n = 0;
    tx = 8'hFF;
    miso = 1'b1;
  end
  // Released line: inverse of last bit, so a stale value cannot pass
  always @(posedge cs_n) miso = ~miso;
  always @(posedge sclk) if (!cs_n) begin
    sh = {sh[6:0], mosi};
    n = (n + 1) % 8;
    if (n == 0) got(sh);
  end
  always @(negedge sclk) if (!cs_n) begin
    tx = (n == 0) ? (q.size() > 0 ? q.pop_front() : 8'hFF) : tx << 1;
    miso = tx[7];
  end
endmodule : mcs_card

/* File: tb/testbench.sv */
// Self-checking bench for the card link host
`include "mcs_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mcs_pkg::*;
  typedef struct {mcs_word_t ctrl, arg, exp, mask;} mcs_row_t;
  logic clk, ce, rst, wr, rd, sclk, cs_n, mosi, miso;
  logic [7:0] addr;
  mcs_word_t wdata, rd_data, d;
  int bad_count, num_checks, cyc;
  mcs_row_t rows[17] = '{
    '{32'h2000, 32'h0, 32'h0, 32'hFF00}, '{32'h100, 32'h0, 32'h01, 32'hFFFF},
    '{32'h106, 32'h0, 32'h05, 32'hFFFF}, '{32'h108, 32'h1AA, 32'h01, 32'hFFFF},
    '{32'h129, 32'h0, 32'h00, 32'hFFFF}, '{32'h518, 32'h0, 32'h00, 32'hFFFF},
    '{32'h518, 32'hBAD, 32'h0B2000, 32'hFFFFFF}, '{32'h10519, 32'h0, 32'h00, 32'hFFFF},
    '{32'h8309, 32'h0, 32'h00, 32'hFFFF}, '{32'h311, 32'h0, 32'h00, 32'hFFFF},
    '{32'h311, 32'hBAD, 32'h080200, 32'hFFFF00}, '{32'h311, 32'hC00, 32'h400, 32'hFFFF},
    '{32'h1312, 32'h0, 32'h00, 32'hFFFF}, '{32'h10C, 32'h0, 32'h00, 32'hFFFF},
    '{32'h311, 32'h1FE, 32'h1000, 32'h1100}, '{32'h4126, 32'h0, 32'h00, 32'hFFFF},
    '{32'h800, 32'h0, 32'h0, 32'hFF00}};
  mcs_host #(.DATA_WAIT_BYTES(16'h0010), .BUSY_WAIT_BYTES(16'h0010)) uut (.clk(clk),
    .ce(ce), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rd_data_q(rd_data),
    .sclk_q(sclk), .cs_n_q(cs_n), .mosi_q(mosi), .miso(miso));
  mcs_card #(.LEN(4)) card (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      complete_run();
    end
  end
  task check(mcs_word_t got, mcs_word_t exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task wr_reg(logic [7:0] a, mcs_word_t v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task rd_reg(logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rd_data;
    @(posedge clk);
  endtask : rd_reg
  // Poll the active flag with a bound; a hang shows up in the compare
  task run(mcs_word_t ctrl, mcs_word_t arg);
    wr_reg(`MCS_A_ARG, arg);
    wr_reg(`MCS_A_CTRL, ctrl);
    d = 32'h100;
    for (int i = 0; i < 3000 && d[8] !== 1'b0; i++) rd_reg(`MCS_A_STAT);
  endtask : run
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`MCS_A_CFG);
    check(d, 32'h0000_1200);
    rd_reg(8'h20);
    check(d, 32'h0);
    $display("test defaults done");
    // Partial blocks of 4 bytes keep the run short
    wr_reg(`MCS_A_CFG, 32'h1804);
    wr_reg(`MCS_A_BUFP, 32'h0);
    for (int i = 0; i < 4; i++) wr_reg(`MCS_A_BUFD, 32'h30 + i);
    foreach (rows[i]) begin
      run(rows[i].ctrl, rows[i].arg);
      rd_reg(`MCS_A_STAT);
      check(d & rows[i].mask, rows[i].exp);
      $display("test %0d done", i);
    end
    wr_reg(`MCS_A_BUFP, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd_reg(`MCS_A_BUFD);
      check(d, 32'hA0 + i);
    end
    $display("test buffer done");
    wr_reg(`MCS_A_CTRL, 32'h311);
    repeat (100) @(posedge clk);
    // Enable low in mid-frame must freeze the link pins
    ce <= 1'b0;
    @(negedge clk);
    d = {29'h0, sclk, cs_n, mosi};
    repeat (20) @(negedge clk);
    check({29'h0, sclk, cs_n, mosi}, d);
    check(d & 32'h2, 32'h0);
    $display("test freeze done");
    @(posedge clk);
    ce <= 1'b1;
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd_reg(`MCS_A_STAT);
    check(d & 32'h100, 32'h0);
    check({31'h0, cs_n}, 32'h1);
    $display("test reset done");
    complete_run();
  end
endmodule : testbench
